/* File: hw/loop_alarm_pkg.sv */
`default_nettype none
package loop_alarm_pkg;

  // Register offsets of the readback bank
  localparam logic [15:0] OFS_REF_LIVE     = 16'h007C;
  localparam logic [15:0] OFS_COMBINED     = 16'h007D;
  localparam logic [15:0] OFS_STICKY       = 16'h007E;
  localparam logic [15:0] OFS_ALARM_SPARE  = 16'h007F;
  localparam logic [15:0] OFS_STATE_SELECT = 16'h0082;
  localparam logic [15:0] OFS_AVG_CODE     = 16'h0083;
  localparam logic [15:0] OFS_CMP_CODE     = 16'h0084;
  localparam logic [15:0] OFS_CONV_STATUS  = 16'h0085;
  localparam logic [15:0] OFS_EXIT_STEP    = 16'h0086;
  localparam logic [15:0] OFS_STATUS_SPARE = 16'h0087;

  // Live alarm field positions
  localparam int BIT_REF_NEAR   = 7;
  localparam int BIT_REF_ACQ    = 6;
  localparam int BIT_REF_LOCK   = 5;
  localparam int BIT_REF_HOLD   = 4;
  // Combined alarm field positions
  localparam int BIT_SYNC_REQ   = 4;
  localparam int BIT_BOTH_LOCK  = 3;
  localparam int BIT_PHASE_OK   = 2;
  localparam int BIT_NEVER_SYNC = 1;
  localparam int BIT_SYN_NEAR   = 0;
  // Sticky record field positions
  localparam int BIT_STK_SYN_ACQ = 6;
  localparam int BIT_STK_REF_ACQ = 5;
  localparam int BIT_STK_HOLD    = 4;
  // Converter status field positions
  localparam int BIT_ACTIVE_LOS = 3;
  localparam int BIT_FAST_REF   = 2;
  localparam int BIT_ADC_FAST   = 1;
  localparam int BIT_ADC_RANGE  = 0;

  // Near lock declared at one sixteenth of the limit
  localparam int NEAR_LOCK_SHIFT = 4;
  // Averaging weight of the holdover code, as a shift
  localparam int AVG_SHIFT = 3;
  localparam int STICKY_W  = 7;

  // Reference-loop state codes as read back
  localparam logic [2:0] CODE_RESET   = 3'h0;
  localparam logic [2:0] CODE_ACQUIRE = 3'h1;
  localparam logic [2:0] CODE_LOCKED  = 3'h2;
  localparam logic [2:0] CODE_INVALID = 3'h3;
  localparam logic [2:0] CODE_HOLD    = 3'h4;
  localparam logic [2:0] CODE_EXIT    = 3'h5;

  typedef enum logic [5:0] {
    ST_RESET   = 6'h01,
    ST_ACQUIRE = 6'h02,
    ST_LOCKED  = 6'h04,
    ST_INVALID = 6'h08,
    ST_HOLD    = 6'h10,
    ST_EXIT    = 6'h20
  } ref_state_t;

endpackage
`default_nettype wire

/* File: hw/sticky_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module sticky_bank #(
  parameter int W = 7
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         reset_n,  // Async reset
  input  wire logic         ce,       // Clock enable
  input  wire logic [W-1:0] set,      // Live events
  input  wire logic         clear,    // One-cycle clear pulse
  output logic      [W-1:0] flags     // Sticky records
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          flags[i] <= 1'b0;
        end else if (ce) begin
          // Set beats clear so an event in the clear cycle survives
          if (set[i]) begin
            flags[i] <= 1'b1;
          end else if (clear) begin
            flags[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // sticky_bank
`default_nettype wire

/* File: hw/loop_alarm_status_readback.sv */
// Operation
// - Reference near-lock flag set when lock count reaches limit/16, bit 7.
// - Combined bit 0 is synthesis-loop near lock at limit/16.
// - Live register: acquiring bit 6, locked 5, holdover 4, input loss 3:0.
// - Sync request reads 1 when synthesis loop locked/disabled but unsynchronized.
// - Combined lock reads 1 only while both loops are locked.
// - Phase bit reads 1 when output phase is stable, else 0.
// - Sync status reads 0 once synchronized by pin or port request.
// - Sticky register keeps acquisition, holdover and input-loss records.
// - State register bits 6:5 give the preferred reference index.
// - State register bits 4:3 give the active reference index.
// - Three-bit state field encodes reset..exit as 000 through 101.
// - Comparator on bit 7, current code 6:0, averaged code one below.
// - Converter status bit 3 is loss of the active reference.
// - Bit 2 shows an enabled reference faster than local oscillator.
// - Bit 1 reads 1 while tuning voltage moves quickly.
// - Bit 0 reads 1 while tuning voltage is out of range.
// - Exit register bits 4:3 report the holdover exit step.
// - A live flag reaches the alarm output only with its mask set.
`timescale 1ns/1ns
`default_nettype none
module loop_alarm_status_readback (
  input  wire logic        clk_sys,            // 25 MHz control clock
  input  wire logic        reset_n,            // Async reset, active low
  input  wire logic        ce,                 // Clock enable, freezes state
  input  wire logic        rd_en,              // Read strobe
  input  wire logic [15:0] rd_addr,            // Read register address
  output logic      [7:0]  rd_data,            // Read data, registered
  output logic             rd_valid,           // Read data valid pulse
  input  wire logic [15:0] ref_lock_count,     // Reference lock counter
  input  wire logic [15:0] ref_lock_limit,     // Reference lock limit
  input  wire logic        ref_acquiring,      // Reference loop acquiring
  input  wire logic        ref_locked,         // Reference loop locked
  input  wire logic        ref_holdover,       // Reference loop in holdover
  input  wire logic        ref_exit_active,    // Converter-assisted exit running
  input  wire logic [3:0]  ref_los,            // Loss of signal per input
  input  wire logic [3:0]  ref_enable,         // Enabled reference inputs
  input  wire logic [3:0]  ref_fast,           // Input faster than oscillator
  input  wire logic [1:0]  active_ref,         // Input driving the loop
  input  wire logic [15:0] synth_lock_count,   // Synthesis lock counter
  input  wire logic [15:0] synth_lock_limit,   // Synthesis lock limit
  input  wire logic        synth_locked,       // Synthesis loop locked
  input  wire logic        synth_disabled,     // Synthesis loop disabled
  input  wire logic        synth_acquiring,    // Synthesis loop acquiring
  input  wire logic        ext_sync_pin,       // External sync pin, async
  input  wire logic        spi_sync_req,       // Port sync request pulse
  input  wire logic        phase_stable,       // Output phase stable
  input  wire logic        holdover_cmp,       // Converter vs tuning voltage
  input  wire logic [6:0]  dac_code,           // Current holdover code
  input  wire logic        adc_fast,           // Tuning voltage moving quickly
  input  wire logic        tuning_voltage_out_of_range, // Tuning voltage out of range
  input  wire logic [1:0]  holdover_exit_step, // Exit sequence step
  input  wire logic [7:0]  mask_ref,           // Live alarm masks
  input  wire logic [4:0]  mask_comb,          // Combined alarm masks
  input  wire logic        sticky_clear,       // Clear pulse for records
  output logic             alarm_out           // Masked alarm, registered
);
  import loop_alarm_pkg::*;

  ref_state_t        state;
  ref_state_t        next_state;
  logic [2:0]        state_code;
  logic              ref_near;
  logic              synth_near;
  logic [2:0]        sync_pipe;
  logic              ext_level;
  logic              ext_rise;
  logic              has_synced;
  logic [1:0]        pref_idx;
  logic [1:0]        next_pref;
  logic              pref_found;
  logic [3:0]        candidates;
  logic [9:0]        avg_acc;
  logic [6:0]        avg_code;
  logic [STICKY_W-1:0] sticky_set;
  logic [STICKY_W-1:0] sticky;
  logic [7:0]        live_reg;
  logic [7:0]        comb_reg;
  logic [7:0]        select_reg;
  logic [7:0]        status_reg;
  logic [7:0]        next_rd_data;

  // Near lock compares against the limit divided by sixteen
  assign ref_near   = ref_lock_count >= (ref_lock_limit >> NEAR_LOCK_SHIFT);
  assign synth_near = synth_lock_count >= (synth_lock_limit >> NEAR_LOCK_SHIFT);

  // External sync pin crossing; only the agreed later stages are looked at
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_pipe <= 3'h0;
    end else if (ce) begin
      sync_pipe <= {sync_pipe[1:0], ext_sync_pin};
    end
  end

  assign ext_rise = (sync_pipe[1] == sync_pipe[2]) && sync_pipe[2] && !ext_level;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_level <= 1'b0;
    end else if (ce && (sync_pipe[1] == sync_pipe[2])) begin
      ext_level <= sync_pipe[2];
    end
  end

  // Once synchronized the device stays synchronized until reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      has_synced <= 1'b0;
    end else if (ce && (ext_rise || spi_sync_req)) begin
      has_synced <= 1'b1;
    end
  end

  // Reference-loop state tracking
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: begin
        if (ref_acquiring) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (ref_locked) begin
          next_state = ST_LOCKED;
        end else if (ref_holdover) begin
          next_state = ST_HOLD;
        end
      end
      ST_LOCKED: begin
        if (ref_holdover) begin
          next_state = ST_HOLD;
        end else if (!ref_locked) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_HOLD: begin
        if (ref_exit_active) begin
          next_state = ST_EXIT;
        end else if (!ref_holdover) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_EXIT: begin
        if (!ref_exit_active) begin
          next_state = ST_ACQUIRE;
        end
      end
      ST_INVALID: begin
        next_state = ST_RESET;
      end
      default: begin
        next_state = ST_INVALID;
      end
    endcase
    // Locked and holdover together cannot both be true
    if (ref_locked && ref_holdover) begin
      next_state = ST_INVALID;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_comb begin
    case (state)
      ST_RESET:   state_code = CODE_RESET;
      ST_ACQUIRE: state_code = CODE_ACQUIRE;
      ST_LOCKED:  state_code = CODE_LOCKED;
      ST_HOLD:    state_code = CODE_HOLD;
      ST_EXIT:    state_code = CODE_EXIT;
      default:    state_code = CODE_INVALID;
    endcase
  end

  // Lowest-index healthy enabled input wins; last choice kept if none
  assign candidates = ref_enable & ~ref_los;

  always_comb begin
    next_pref  = pref_idx;
    pref_found = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (candidates[i]) begin
        next_pref  = 2'(i);
        pref_found = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pref_idx <= 2'h0;
    end else if (ce && pref_found) begin
      pref_idx <= next_pref;
    end
  end

  // Running average, three fraction bits keep small steps from vanishing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      avg_acc <= 10'h000;
    end else if (ce) begin
      avg_acc <= avg_acc + {3'h0, dac_code} - {3'h0, avg_acc[9:AVG_SHIFT]};
    end
  end

  assign avg_code = avg_acc[9:AVG_SHIFT];

  assign sticky_set = {synth_acquiring, ref_acquiring, ref_holdover, ref_los};

  sticky_bank #(
    .W (STICKY_W)
  ) u_sticky (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .set     (sticky_set),
    .clear   (sticky_clear),
    .flags   (sticky)
  );

  assign live_reg = {ref_near, ref_acquiring, ref_locked, ref_holdover, ref_los};
  assign comb_reg = {3'h0,
                     (synth_locked || synth_disabled) && !has_synced,
                     ref_locked && synth_locked,
                     phase_stable,
                     !has_synced,
                     synth_near};
  assign select_reg = {1'b0, pref_idx, active_ref, state_code};
  assign status_reg = {4'h0,
                       ref_los[active_ref],
                       |(ref_enable & ref_fast),
                       adc_fast,
                       tuning_voltage_out_of_range};

  always_comb begin
    case (rd_addr)
      OFS_REF_LIVE:     next_rd_data = live_reg;
      OFS_COMBINED:     next_rd_data = comb_reg;
      OFS_STICKY:       next_rd_data = {1'b0, sticky};
      OFS_STATE_SELECT: next_rd_data = select_reg;
      OFS_AVG_CODE:     next_rd_data = {1'b0, avg_code};
      OFS_CMP_CODE:     next_rd_data = {holdover_cmp, dac_code};
      OFS_CONV_STATUS:  next_rd_data = status_reg;
      OFS_EXIT_STEP:    next_rd_data = {3'h0, holdover_exit_step, 3'h0};
      default:          next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= next_rd_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_out <= 1'b0;
    end else if (ce) begin
      alarm_out <= |(live_reg & mask_ref) || |(comb_reg[4:0] & mask_comb);
    end
  end

  chk_ref_near_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_REF_LIVE |=>
      rd_data[BIT_REF_NEAR] ==
        ($past(ref_lock_count) >= ($past(ref_lock_limit) >> NEAR_LOCK_SHIFT)))
    else $error("reference near lock readback wrong");

  chk_synth_near_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_COMBINED |=>
      rd_data[BIT_SYN_NEAR] ==
        ($past(synth_lock_count) >= ($past(synth_lock_limit) >> NEAR_LOCK_SHIFT)))
    else $error("synthesis near lock readback wrong");

  chk_both_lock_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_COMBINED |=>
      rd_data[BIT_BOTH_LOCK] == ($past(ref_locked) && $past(synth_locked)))
    else $error("combined lock bit wrong");

  chk_port_sync_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && spi_sync_req ##[1:4] ce && rd_en && rd_addr == OFS_COMBINED |=>
      !rd_data[BIT_NEVER_SYNC])
    else $error("port sync request not recorded");

  chk_live_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_REF_LIVE |=>
      rd_data[BIT_REF_ACQ:0] ==
        {$past(ref_acquiring), $past(ref_locked), $past(ref_holdover), $past(ref_los)})
    else $error("live alarm readback wrong");

  chk_sync_req_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_COMBINED |=>
      rd_data[BIT_SYNC_REQ] ==
        (($past(synth_locked) || $past(synth_disabled)) && rd_data[BIT_NEVER_SYNC]))
    else $error("sync request readback wrong");

  chk_exit_step_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_EXIT_STEP |=>
      rd_data == {3'h0, $past(holdover_exit_step), 3'h0})
    else $error("holdover exit step readback wrong");

  chk_pin_sync_seen: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ce && ext_sync_pin)[*6] |=> has_synced)
    else $error("sync pin pulse not recorded");

  chk_sticky_set_wins: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && ref_holdover && sticky_clear |=> sticky[BIT_STK_HOLD])
    else $error("holdover record lost on clear");

  chk_sticky_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sticky[BIT_STK_REF_ACQ] && !sticky_clear |=> sticky[BIT_STK_REF_ACQ])
    else $error("acquisition record dropped without clear");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && (rd_addr == OFS_ALARM_SPARE || rd_addr == OFS_STATUS_SPARE) |=>
      rd_data == 8'h00 && rd_valid)
    else $error("reserved register not zero");

  chk_alarm_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && mask_ref == 8'h00 && mask_comb == 5'h00 |=> !alarm_out)
    else $error("alarm raised with all masks clear");

  chk_state_legal: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && ref_locked && ref_holdover |=> state_code == CODE_INVALID)
    else $error("invalid state not reported");

  // Invalid is only left once the contradictory inputs are gone
  chk_invalid_leaves: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && state_code == CODE_INVALID && !(ref_locked && ref_holdover) |=>
      state_code == CODE_RESET)
    else $error("invalid state not left for reset");

  chk_active_los: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ce && rd_en && rd_addr == OFS_CONV_STATUS |=>
      rd_data[BIT_ACTIVE_LOS] == $past(ref_los[active_ref]) && rd_data[7:4] == 4'h0)
    else $error("active reference loss bit wrong");

endmodule // loop_alarm_status_readback
`default_nettype wire

/* File: testbench/test_loop_alarm_status_readback.sv */
`timescale 1ns/1ns
`default_nettype none
module test_loop_alarm_status_readback;
  import loop_alarm_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n, ce, rd_en, rd_valid, alarm_out;
  logic [15:0] rd_addr, ref_lock_count, ref_lock_limit, synth_lock_count, synth_lock_limit;
  logic [7:0]  rd_data, mask_ref;
  logic        ref_acquiring, ref_locked, ref_holdover, ref_exit_active;
  logic [3:0]  ref_los, ref_enable, ref_fast;
  logic [1:0]  active_ref, holdover_exit_step;
  logic        synth_locked, synth_disabled, synth_acquiring, ext_sync_pin, spi_sync_req;
  logic        phase_stable, holdover_cmp, adc_fast, tuning_voltage_out_of_range, sticky_clear;
  logic [6:0]  dac_code;
  logic [4:0]  mask_comb;
  int          mismatches = 0;
  int          compares = 0;

  loop_alarm_status_readback DUT (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .ref_lock_count(ref_lock_count), .ref_lock_limit(ref_lock_limit),
    .ref_acquiring(ref_acquiring), .ref_locked(ref_locked), .ref_holdover(ref_holdover),
    .ref_exit_active(ref_exit_active), .ref_los(ref_los), .ref_enable(ref_enable),
    .ref_fast(ref_fast), .active_ref(active_ref), .synth_lock_count(synth_lock_count),
    .synth_lock_limit(synth_lock_limit), .synth_locked(synth_locked),
    .synth_disabled(synth_disabled), .synth_acquiring(synth_acquiring),
    .ext_sync_pin(ext_sync_pin), .spi_sync_req(spi_sync_req), .phase_stable(phase_stable),
    .holdover_cmp(holdover_cmp), .dac_code(dac_code), .adc_fast(adc_fast),
    .tuning_voltage_out_of_range(tuning_voltage_out_of_range), .holdover_exit_step(holdover_exit_step),
    .mask_ref(mask_ref), .mask_comb(mask_comb), .sticky_clear(sticky_clear),
    .alarm_out(alarm_out));

  always #20 clk_sys = ~clk_sys;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  // Read is taken at the posedge, answer sampled at the following negedge
  task automatic check_reg(input logic [15:0] a, input logic [7:0] exp,
                           input logic [7:0] mask = 8'hFF);
    @(negedge clk_sys);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_en = 1'b0;
    compares++;
    if (rd_valid !== 1'b1 || (rd_data & mask) !== exp)
      fail($sformatf("reg %h read %h want %h", a, rd_data, exp));
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) fail($sformatf("%s is %b want %b", what, got, exp));
  endtask

  task automatic do_reset();
    reset_n = 1'b0;
    cyc(20);
    reset_n = 1'b1;
  endtask

  task automatic idle();
    {ce, rd_en, rd_addr} = {1'b1, 1'b0, 16'h0000};
    {ref_lock_count, synth_lock_count} = 32'h0000_0000;
    {ref_lock_limit, synth_lock_limit} = {16'h0100, 16'h0100};
    {ref_acquiring, ref_locked, ref_holdover, ref_exit_active} = 4'h0;
    {ref_los, ref_enable, ref_fast, active_ref, holdover_exit_step} = 16'h0000;
    {synth_locked, synth_disabled, synth_acquiring, ext_sync_pin, spi_sync_req} = 5'h00;
    {phase_stable, holdover_cmp, adc_fast, tuning_voltage_out_of_range, sticky_clear} = 5'h00;
    {dac_code, mask_ref, mask_comb} = 20'h0_0000;
  endtask

  task automatic t_reset_values();
    check_reg(OFS_COMBINED, 8'h02);
    check_reg(OFS_STATE_SELECT, 8'h00);
    check_reg(OFS_STICKY, 8'h00);
  endtask

  // One below the limit/16 threshold, then exactly on it
  task automatic t_near_lock();
    ref_lock_count = 16'h000F;
    synth_lock_count = 16'h000F;
    check_reg(OFS_REF_LIVE, 8'h00, 8'h80);
    check_reg(OFS_COMBINED, 8'h00, 8'h01);
    ref_lock_count = 16'h0010;
    synth_lock_count = 16'h0010;
    check_reg(OFS_REF_LIVE, 8'h80, 8'h80);
    check_reg(OFS_COMBINED, 8'h01, 8'h01);
    {ref_lock_count, synth_lock_count} = 32'h0000_0000;
  endtask

  // Walks every state code and checks the live flags on the way
  task automatic t_states();
    ref_acquiring = 1'b1;
    ref_los = 4'hA;
    check_reg(OFS_REF_LIVE, 8'h4A);
    check_reg(OFS_STATE_SELECT, 8'h01, 8'h07);
    {ref_acquiring, ref_locked, ref_los} = 6'b01_0101;
    check_reg(OFS_REF_LIVE, 8'h25);
    check_reg(OFS_STATE_SELECT, 8'h02, 8'h07);
    {ref_locked, ref_holdover} = 2'b01;
    cyc(2);
    check_reg(OFS_REF_LIVE, 8'h15);
    check_reg(OFS_STATE_SELECT, 8'h04, 8'h07);
    ref_exit_active = 1'b1;
    check_reg(OFS_STATE_SELECT, 8'h05, 8'h07);
    ref_holdover = 1'b0;
    cyc(1);
    ref_exit_active = 1'b0;
    check_reg(OFS_STATE_SELECT, 8'h01, 8'h07);
    {ref_locked, ref_holdover} = 2'b11;
    check_reg(OFS_STATE_SELECT, 8'h03, 8'h07);
    {ref_locked, ref_holdover, ref_los} = 6'h00;
    cyc(1);
    check_reg(OFS_STATE_SELECT, 8'h00, 8'h07);
  endtask

  task automatic t_combined();
    synth_disabled = 1'b1;
    check_reg(OFS_COMBINED, 8'h12);
    {synth_disabled, synth_locked} = 2'b01;
    check_reg(OFS_COMBINED, 8'h12);
    {ref_locked, phase_stable} = 2'b11;
    check_reg(OFS_COMBINED, 8'h1E);
    spi_sync_req = 1'b1;
    cyc(1);
    spi_sync_req = 1'b0;
    check_reg(OFS_COMBINED, 8'h0C);
    {ref_locked, phase_stable, synth_locked} = 3'b000;
    cyc(2);
    check_reg(OFS_COMBINED, 8'h00);
    do_reset();
    check_reg(OFS_COMBINED, 8'h02);
    ext_sync_pin = 1'b1;
    cyc(8);
    check_reg(OFS_COMBINED, 8'h00);
    ext_sync_pin = 1'b0;
  endtask

  task automatic t_sticky();
    sticky_clear = 1'b1;
    cyc(1);
    sticky_clear = 1'b0;
    check_reg(OFS_STICKY, 8'h00);
    {synth_acquiring, ref_acquiring, ref_holdover, ref_los} = 7'h79;
    cyc(1);
    {synth_acquiring, ref_acquiring, ref_holdover, ref_los} = 7'h00;
    cyc(2);
    check_reg(OFS_STICKY, 8'h79);
    {ref_holdover, ref_los} = 5'h12;
    sticky_clear = 1'b1;
    cyc(1);
    sticky_clear = 1'b0;
    {ref_holdover, ref_los} = 5'h00;
    check_reg(OFS_STICKY, 8'h12);
  endtask

  task automatic t_holdover();
    {ref_enable, ref_los, active_ref} = 10'b1111_0011_11;
    check_reg(OFS_STATE_SELECT, 8'h58, 8'h78);
    check_reg(OFS_CONV_STATUS, 8'h00);
    {ref_los, ref_fast} = 8'b1011_0100;
    check_reg(OFS_STATE_SELECT, 8'h58, 8'h78);
    check_reg(OFS_CONV_STATUS, 8'h0C);
    {ref_enable, adc_fast} = 5'b1011_1;
    check_reg(OFS_CONV_STATUS, 8'h0A);
    {adc_fast, tuning_voltage_out_of_range, ref_los} = 6'b01_0000;
    check_reg(OFS_CONV_STATUS, 8'h01);
    {holdover_cmp, dac_code, holdover_exit_step} = {1'b1, 7'h2A, 2'h2};
    check_reg(OFS_CMP_CODE, 8'hAA);
    check_reg(OFS_EXIT_STEP, 8'h10);
    cyc(200);
    check_reg(OFS_AVG_CODE, 8'h2A);
  endtask

  task automatic t_reserved();
    check_reg(OFS_ALARM_SPARE, 8'h00);
    check_reg(OFS_STATUS_SPARE, 8'h00);
    check_reg(16'h0080, 8'h00);
    check_reg(16'h0000, 8'h00);
    cyc(1);
    ce = 1'b0;
    rd_en = 1'b1;
    cyc(2);
    check_bit(rd_valid, 1'b0, "rd_valid with ce low");
    {ce, rd_en} = 2'b10;
  endtask

  task automatic t_alarm();
    {ref_los, mask_ref, mask_comb} = {4'h1, 8'hFE, 5'h00};
    cyc(2);
    check_bit(alarm_out, 1'b0, "alarm masked los");
    mask_ref = 8'h01;
    cyc(2);
    check_bit(alarm_out, 1'b1, "alarm unmasked los");
    {ref_los, mask_ref} = 12'h000;
    do_reset();
    mask_comb = 5'h02;
    cyc(2);
    check_bit(alarm_out, 1'b1, "alarm never synced");
    mask_comb = 5'h00;
    cyc(2);
    check_bit(alarm_out, 1'b0, "alarm comb masked");
  endtask

  task automatic results();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #400_000;
    fail("watchdog expired");
    results();
  end

  initial begin
    idle();
    reset_n = 1'b0;
    @(negedge clk_sys);
    do_reset();
    t_reset_values();
    t_near_lock();
    t_states();
    t_combined();
    t_sticky();
    t_holdover();
    t_reserved();
    t_alarm();
    results();
  end
endmodule // test_loop_alarm_status_readback
`default_nettype wire
